// ### rtl/sbypor_top.sv
`timescale 1ns/100ps
// Overview of operation
// - in normal mode the selected standby pin edge enters standby
// - entering standby through the pin clears the normal-mode flag
// - opposite pin edge or serial flag write restores normal defaults
// - standby trigger edge selectable: falling by default, or rising
// - serial data sampled on clock rise, driven on clock fall
// - serial data open-drain two-way; serial clock is an input
// - reset delay starts above rising threshold; release after delay
// - reset output driven low below falling threshold once the input synchroniser passes it, with no delay count
// - disabled channel discharges only when its setting bit is set
module sbypor_top
   import sbypor_pkg::*;
#(
   parameter int POR_DELAY_CYC = POR_DELAY_CYCLES
)(
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic standby_request_pin_i,
   input wire logic standby_edge_rising_i,
   input wire logic serial_clk_i,
   input wire logic serial_frame_i,
   input wire logic serial_data_i,
   output logic serial_data_o,
   output logic serial_data_oe_o,
   input wire logic supply_above_rise_i,
   input wire logic supply_below_fall_i,
   input wire logic [THRESH_W-1:0] rising_threshold_setting_i,
   input wire logic [THRESH_W-1:0] falling_threshold_setting_i,
   output logic [THRESH_W-1:0] rising_threshold_o,
   output logic [THRESH_W-1:0] falling_threshold_o,
   input wire logic [NUM_CH-1:0] channel_enable_i,
   input wire logic [NUM_CH-1:0] disabled_discharge_setting_i,
   output logic [NUM_CH-1:0] discharge_en_o,
   output logic normal_mode_flag_o,
   output logic standby_o,
   output logic restore_defaults_o,
   output logic por_o,
   output logic por_oe_o
);

   localparam int CNT_W = $clog2(POR_DELAY_CYC + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(POR_DELAY_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;

   // ----------------------------------------------------------------
   // serial link in its own clock domain
   // ----------------------------------------------------------------
   sbypor_wr_if wr_if ();

   sbypor_serial_link u_link (
      .serial_clk_i(serial_clk_i),
      .reset_n_i(reset_n_i),
      .serial_frame_i(serial_frame_i),
      .serial_data_i(serial_data_i),
      .serial_data_oe_o(serial_data_oe_o),
      .wr(wr_if.link)
   );

   // open-drain: only ever pulls low
   assign serial_data_o = 1'h0;
   assign por_o = 1'h0;

   // ----------------------------------------------------------------
   // pin synchronisers and filtered levels
   // ----------------------------------------------------------------
   logic [SYNC_W-1:0] pin_raw;
   logic [SYNC_W-1:0] s1_q, s2_q, s3_q, filt_q;
   logic [SYNC_W-1:0] s1_d, s2_d, s3_d, filt_d;
   logic primed_q, primed_d;
   logic [SYNC_W-1:0] fill_q, fill_d;
   logic tg1_q, tg2_q, tg3_q;
   logic tg1_d, tg2_d, tg3_d;

   assign pin_raw[IDX_PIN] = standby_request_pin_i;
   assign pin_raw[IDX_ABOVE] = supply_above_rise_i;
   assign pin_raw[IDX_BELOW] = supply_below_fall_i;

   always_comb begin
      s1_d = pin_raw;
      s2_d = s1_q;
      s3_d = s2_q;
      filt_d = primed_q ? sbypor_filter(s2_q, s3_q, filt_q) : s2_q;
      // prime only once the third stage holds a real pin sample
      fill_d = {fill_q[SYNC_W-2:0], 1'h1};
      primed_d = primed_q | (fill_q[SYNC_W-1] & (s2_q == s3_q));
      tg1_d = wr_if.wr_toggle;
      tg2_d = tg1_q;
      tg3_d = tg2_q;
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s1_q <= SYNC_RST;
         s2_q <= SYNC_RST;
         s3_q <= SYNC_RST;
         filt_q <= SYNC_RST;
         primed_q <= 1'h0;
         fill_q <= SYNC_RST;
         tg1_q <= 1'h0;
         tg2_q <= 1'h0;
         tg3_q <= 1'h0;
      end else if (ce_i) begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         filt_q <= filt_d;
         primed_q <= primed_d;
         fill_q <= fill_d;
         tg1_q <= tg1_d;
         tg2_q <= tg2_d;
         tg3_q <= tg3_d;
      end
   end

   logic pin_rise, pin_fall, wr_evt, wr_bit;
   logic enter_sby, exit_sby;
   logic [SYNC_W-1:0] lvl_now;

   assign lvl_now = sbypor_filter(s2_q, s3_q, filt_q);
   assign pin_rise = primed_q & lvl_now[IDX_PIN] & ~filt_q[IDX_PIN];
   assign pin_fall = primed_q & ~lvl_now[IDX_PIN] & filt_q[IDX_PIN];
   assign wr_evt = tg2_q ^ tg3_q;
   // byte loads on the same link clock edge as the toggle and stays stable for many link clocks after it
   assign wr_bit = wr_if.wr_data[FLAG_BIT];

   // trigger edge select and its opposite for the exit
   assign enter_sby = (standby_edge_rising_i ? pin_rise : pin_fall)
                      | (wr_evt & ~wr_bit);
   assign exit_sby = (standby_edge_rising_i ? pin_fall : pin_rise)
                     | (wr_evt & wr_bit);

   // ----------------------------------------------------------------
   // mode state machine
   // ----------------------------------------------------------------
   sbypor_mode_e mode_q, mode_d;
   logic flag_q, flag_d;
   logic restore_q, restore_d;
   logic standby_q, standby_d;

   always_comb begin
      mode_d = mode_q;
      flag_d = flag_q;
      restore_d = 1'h0;
      case (mode_q)
         SBYPOR_NORMAL: begin
            if (enter_sby) begin
               mode_d = SBYPOR_STANDBY;
               flag_d = 1'h0;
            end
         end
         SBYPOR_STANDBY: begin
            if (exit_sby) begin
               mode_d = SBYPOR_NORMAL;
               flag_d = 1'h1;
               restore_d = 1'h1;
            end
         end
         default: begin
            mode_d = SBYPOR_NORMAL;
            flag_d = NORMAL_FLAG_RST;
         end
      endcase
      standby_d = (mode_d == SBYPOR_STANDBY);
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mode_q <= SBYPOR_NORMAL;
         flag_q <= NORMAL_FLAG_RST;
         restore_q <= 1'h0;
         standby_q <= 1'h0;
      end else if (ce_i) begin
         mode_q <= mode_d;
         flag_q <= flag_d;
         restore_q <= restore_d;
         standby_q <= standby_d;
      end
   end

   assign standby_o = standby_q;
   assign normal_mode_flag_o = flag_q;
   assign restore_defaults_o = restore_q;

   // ----------------------------------------------------------------
   // power-on reset sequencer
   // ----------------------------------------------------------------
   sbypor_por_e por_q, por_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic por_oe_q, por_oe_d;
   logic above, below;

   assign above = lvl_now[IDX_ABOVE];
   assign below = lvl_now[IDX_BELOW];

   always_comb begin
      por_d = por_q;
      cnt_d = cnt_q;
      case (por_q)
         SBYPOR_POR_LOW: begin
            cnt_d = CNT_ZERO;
            if (above && !below) begin
               por_d = SBYPOR_POR_WAIT;
            end
         end
         SBYPOR_POR_WAIT: begin
            cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            if (below) begin
               por_d = SBYPOR_POR_LOW;
            end else if (cnt_q == CNT_LAST) begin
               por_d = SBYPOR_POR_HIGH;
            end
         end
         SBYPOR_POR_HIGH: begin
            if (below) begin
               por_d = SBYPOR_POR_LOW;
            end
         end
         default: begin
            por_d = SBYPOR_POR_LOW;
         end
      endcase
      por_oe_d = (por_d != SBYPOR_POR_HIGH);
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         por_q <= SBYPOR_POR_LOW;
         cnt_q <= CNT_ZERO;
         por_oe_q <= 1'h1;
      end else if (ce_i) begin
         por_q <= por_d;
         cnt_q <= cnt_d;
         por_oe_q <= por_oe_d;
      end
   end

   assign por_oe_o = por_oe_q;

   // ----------------------------------------------------------------
   // thresholds to the comparators and channel discharge
   // ----------------------------------------------------------------
   logic [THRESH_W-1:0] rise_th_q, rise_th_d, fall_th_q, fall_th_d;
   logic [NUM_CH-1:0] dis_q, dis_d;

   always_comb begin
      rise_th_d = rising_threshold_setting_i;
      fall_th_d = falling_threshold_setting_i;
      dis_d = ~channel_enable_i & disabled_discharge_setting_i;
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rise_th_q <= THRESH_RST;
         fall_th_q <= THRESH_RST;
         dis_q <= DISCHARGE_RST;
      end else if (ce_i) begin
         rise_th_q <= rise_th_d;
         fall_th_q <= fall_th_d;
         dis_q <= dis_d;
      end
   end

   assign rising_threshold_o = rise_th_q;
   assign falling_threshold_o = fall_th_q;
   assign discharge_en_o = dis_q;

endmodule // sbypor_top

// ### pkg/sbypor_pkg.sv
package sbypor_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_SYS_MHZ = 100;
   localparam int POR_DELAY_US = 100;
   localparam int POR_DELAY_CYCLES = POR_DELAY_US * CLK_SYS_MHZ;

   // ----------------------------------------------------------------
   // widths and field positions
   // ----------------------------------------------------------------
   localparam int NUM_CH = 6;
   localparam int THRESH_W = 8;
   localparam int BYTE_W = 8;
   localparam int FLAG_BIT = 0;
   localparam int SYNC_W = 3;
   localparam int IDX_PIN = 0;
   localparam int IDX_ABOVE = 1;
   localparam int IDX_BELOW = 2;
   localparam logic [3:0] BIT_CNT_LAST = 4'h7;
   localparam logic [3:0] BIT_CNT_ACK = 4'h8;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic NORMAL_FLAG_RST = 1'h1;
   localparam logic [SYNC_W-1:0] SYNC_RST = 3'h0;
   localparam logic [NUM_CH-1:0] DISCHARGE_RST = 6'h00;
   localparam logic [THRESH_W-1:0] THRESH_RST = 8'h00;
   localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
   localparam logic [3:0] BIT_CNT_RST = 4'h0;

   typedef enum logic {
      SBYPOR_NORMAL,
      SBYPOR_STANDBY
   } sbypor_mode_e;

   typedef enum logic [1:0] {
      SBYPOR_POR_LOW,
      SBYPOR_POR_WAIT,
      SBYPOR_POR_HIGH
   } sbypor_por_e;

   // filtered level follows the input once two sync stages agree
   function automatic logic [SYNC_W-1:0] sbypor_filter(
      input logic [SYNC_W-1:0] s2,
      input logic [SYNC_W-1:0] s3,
      input logic [SYNC_W-1:0] f
   );
      sbypor_filter = ((s2 ~^ s3) & s2) | ((s2 ^ s3) & f);
   endfunction

endpackage

// ### pkg/sbypor_wr_if.sv
`timescale 1ns/100ps
interface sbypor_wr_if;
   logic wr_toggle;
   logic [7:0] wr_data;

   modport link (
      output wr_toggle,
      output wr_data
   );
   modport core (
      input wr_toggle,
      input wr_data
   );
endinterface

// ### rtl/sbypor_serial_link.sv
`timescale 1ns/100ps
module sbypor_serial_link
   import sbypor_pkg::*;
(
   input wire logic serial_clk_i,
   input wire logic reset_n_i,
   input wire logic serial_frame_i,
   input wire logic serial_data_i,
   output logic serial_data_oe_o,
   sbypor_wr_if.link wr
);

   // ----------------------------------------------------------------
   // frame-scoped reset: a frame end clears the bit count, shift register and ack
   // ----------------------------------------------------------------
   logic link_rst_n;
   assign link_rst_n = reset_n_i & serial_frame_i;

   logic [3:0] bit_cnt_q, bit_cnt_d;
   logic [BYTE_W-1:0] shift_q, shift_d;
   logic [BYTE_W-1:0] byte_q, byte_d;
   logic toggle_q, toggle_d;
   logic ack_oe_q, ack_oe_d;

   // ----------------------------------------------------------------
   // receive on the rising serial clock edge
   // ----------------------------------------------------------------
   always_comb begin
      bit_cnt_d = bit_cnt_q;
      shift_d = shift_q;
      byte_d = byte_q;
      toggle_d = toggle_q;
      if (bit_cnt_q == BIT_CNT_ACK) begin
         bit_cnt_d = BIT_CNT_RST;
      end else begin
         shift_d = {shift_q[BYTE_W-2:0], serial_data_i};
         bit_cnt_d = bit_cnt_q + 4'h1;
         if (bit_cnt_q == BIT_CNT_LAST) begin
            byte_d = {shift_q[BYTE_W-2:0], serial_data_i};
            toggle_d = ~toggle_q;
         end
      end
   end

   always_ff @(posedge serial_clk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         bit_cnt_q <= BIT_CNT_RST;
         shift_q <= BYTE_RST;
      end else begin
         bit_cnt_q <= bit_cnt_d;
         shift_q <= shift_d;
      end
   end

   // byte and toggle survive the frame end so the core can collect them
   always_ff @(posedge serial_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         byte_q <= BYTE_RST;
         toggle_q <= 1'h0;
      end else begin
         byte_q <= byte_d;
         toggle_q <= toggle_d;
      end
   end

   // ----------------------------------------------------------------
   // acknowledge driven only on the falling edge
   // ----------------------------------------------------------------
   always_comb begin
      ack_oe_d = (bit_cnt_q == BIT_CNT_ACK);
   end

   always_ff @(negedge serial_clk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         ack_oe_q <= 1'h0;
      end else begin
         ack_oe_q <= ack_oe_d;
      end
   end

   assign serial_data_oe_o = ack_oe_q;
   assign wr.wr_toggle = toggle_q;
   assign wr.wr_data = byte_q;

endmodule // sbypor_serial_link

// ### bench/sbypor_host_model.sv
`timescale 1ns/100ps
module sbypor_host_model (
   input wire logic serial_data_oe_i,
   output logic serial_clk_o,
   output logic serial_frame_o,
   output logic serial_data_o
);
   logic host_low = 1'b0;
   logic ack_ok = 1'b0;

   // pull-up: line low while either side pulls it
   assign serial_data_o = !(host_low || serial_data_oe_i);

   // clock stands high outside frames
   initial begin
      serial_clk_o = 1'b1;
      serial_frame_o = 1'b0;
   end

   // one byte msb first, then the ack clock
   task automatic write_byte(input logic [7:0] val, input int half);
      #3;
      serial_frame_o = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         #(half) serial_clk_o = 1'b0;
         host_low = !val[i];
         #(half) serial_clk_o = 1'b1;
      end
      #(half) serial_clk_o = 1'b0;
      host_low = 1'b0;
      #(half) serial_clk_o = 1'b1;
      ack_ok = !serial_data_o;
      #(half) serial_clk_o = 1'b0;
      #(half) ack_ok = ack_ok && serial_data_o;
      // end the frame first so the idle clock rise shifts nothing
      serial_frame_o = 1'b0;
      #(half) serial_clk_o = 1'b1;
   endtask
endmodule // sbypor_host_model

// ### bench/sbypor_top_sva.sv
`timescale 1ns/100ps
module sbypor_top_sva
   import sbypor_pkg::*;
#(
   parameter int POR_DELAY_CYC = 20
)(
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic standby_request_pin_i,
   input wire logic standby_edge_rising_i,
   input wire logic supply_above_rise_i,
   input wire logic supply_below_fall_i,
   input wire logic [NUM_CH-1:0] channel_enable_i,
   input wire logic [NUM_CH-1:0] disabled_discharge_setting_i,
   input wire logic [NUM_CH-1:0] discharge_en_o,
   input wire logic serial_data_o,
   input wire logic normal_mode_flag_o,
   input wire logic standby_o,
   input wire logic restore_defaults_o,
   input wire logic por_o,
   input wire logic por_oe_o
);
   logic [15:0] hi_cnt_q;
   logic [15:0] hi_cnt_d;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);

   // cycles of good supply while reset output still held low
   always_comb begin
      hi_cnt_d = 16'h0000;
      if (supply_above_rise_i && por_oe_o) begin
         hi_cnt_d = hi_cnt_q + 16'h0001;
      end
   end
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hi_cnt_q <= 16'h0000;
      end else begin
         hi_cnt_q <= hi_cnt_d;
      end
   end

   a_flag_mirror: assert property (
      normal_mode_flag_o == !standby_o)
      else $error("flag and standby disagree");
   a_pin_enter: assert property (
      ($changed(standby_request_pin_i)
      && standby_request_pin_i == standby_edge_rising_i && !standby_o)
      ##1 ($stable({standby_request_pin_i, standby_edge_rising_i}) && ce_i)[*4]
      |=> standby_o) else $error("pin edge did not enter standby");
   a_pin_exit: assert property (
      ($changed(standby_request_pin_i)
      && standby_request_pin_i != standby_edge_rising_i && standby_o)
      ##1 ($stable({standby_request_pin_i, standby_edge_rising_i}) && ce_i)[*4]
      |=> !standby_o) else $error("pin edge did not leave standby");
   a_restore_pulse: assert property (
      restore_defaults_o == $fell(standby_o))
      else $error("restore pulse not tied to standby exit");
   a_por_delay: assert property ($fell(por_oe_o) |->
      hi_cnt_q >= POR_DELAY_CYC + 4 && hi_cnt_q <= POR_DELAY_CYC + 6)
      else $error("reset output released at wrong time");
   a_por_low: assert property (
      (supply_below_fall_i && ce_i)[*6] |-> por_oe_o)
      else $error("reset output not pulled low");
   a_discharge_map: assert property (ce_i |=> discharge_en_o ==
      $past(~channel_enable_i & disabled_discharge_setting_i))
      else $error("discharge enable wrong");
   a_open_drain: assert property (!serial_data_o && !por_o)
      else $error("open-drain output driven high");
endmodule // sbypor_top_sva

bind sbypor_top sbypor_top_sva #(.POR_DELAY_CYC(POR_DELAY_CYC)) sbypor_top_sva_inst (
   .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
   .standby_request_pin_i(standby_request_pin_i),
   .standby_edge_rising_i(standby_edge_rising_i),
   .supply_above_rise_i(supply_above_rise_i),
   .supply_below_fall_i(supply_below_fall_i),
   .channel_enable_i(channel_enable_i),
   .disabled_discharge_setting_i(disabled_discharge_setting_i),
   .discharge_en_o(discharge_en_o), .serial_data_o(serial_data_o),
   .normal_mode_flag_o(normal_mode_flag_o), .standby_o(standby_o),
   .restore_defaults_o(restore_defaults_o), .por_o(por_o),
   .por_oe_o(por_oe_o)
);

// ### bench/sbypor_top_tb.sv
`timescale 1ns/100ps
module sbypor_top_tb import sbypor_pkg::*;;
   localparam int N_DLY = 20;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic ce = 1'b1;
   logic pin = 1'b1;
   logic edge_r = 1'b0;
   logic above = 1'b0;
   logic below = 1'b0;
   logic [7:0] th_r = 8'h00;
   logic [7:0] th_f = 8'h00;
   logic [5:0] ch_en = 6'h00;
   logic [5:0] dis_set = 6'h00;
   logic [7:0] rise_o, fall_o;
   logic [5:0] dis_o;
   logic s_clk, s_frame, s_data, s_oe, s_dout;
   logic por, por_oe, flag, standby_request_pin, restore;
   int num_errors = 0;
   int cmp_count = 0;
   int rst_cnt = 0;
   int cyc = 0;

   always #5 clk_sys = ~clk_sys;

   sbypor_top #(.POR_DELAY_CYC(N_DLY)) sbypor_top_inst (
      .clk_sys_i(clk_sys), .reset_n_i(reset_n), .ce_i(ce),
      .standby_request_pin_i(pin), .standby_edge_rising_i(edge_r),
      .serial_clk_i(s_clk), .serial_frame_i(s_frame),
      .serial_data_i(s_data), .serial_data_o(s_dout),
      .serial_data_oe_o(s_oe), .supply_above_rise_i(above),
      .supply_below_fall_i(below), .rising_threshold_setting_i(th_r),
      .falling_threshold_setting_i(th_f), .rising_threshold_o(rise_o),
      .falling_threshold_o(fall_o), .channel_enable_i(ch_en),
      .disabled_discharge_setting_i(dis_set), .discharge_en_o(dis_o),
      .normal_mode_flag_o(flag), .standby_o(standby_request_pin),
      .restore_defaults_o(restore), .por_o(por), .por_oe_o(por_oe)
   );
   sbypor_host_model sbypor_host_model_inst (
      .serial_data_oe_i(s_oe), .serial_clk_o(s_clk),
      .serial_frame_o(s_frame), .serial_data_o(s_data)
   );

   always @(posedge clk_sys) begin
      if (restore === 1'b1) rst_cnt++;
   end

   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         test_done();
      end
   end

   task automatic check(input string what, input logic [7:0] exp,
         input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
         num_errors++;
      end
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic judge(input logic sby, input int nrst, input int r0);
      check("standby", 8'(sby), 8'(standby_request_pin));
      check("flag", 8'(!sby), 8'(flag));
      check("restores", 8'(nrst), 8'(rst_cnt - r0));
   endtask

   task automatic pin_step(input logic lvl, input logic sby, input int nrst);
      int r0;
      r0 = rst_cnt;
      @(posedge clk_sys);
      pin <= lvl;
      wait_cyc(8);
      judge(sby, nrst, r0);
   endtask

   task automatic ser_step(input logic [7:0] val, input int half,
         input logic sby, input int nrst);
      int r0;
      r0 = rst_cnt;
      sbypor_host_model_inst.write_byte(val, half);
      wait_cyc(6);
      check("ack", 8'h01, 8'(sbypor_host_model_inst.ack_ok));
      judge(sby, nrst, r0);
   endtask

   task automatic t_discharge();
      logic [5:0] hold;
      for (int k = 0; k < 8; k++) begin
         @(posedge clk_sys);
         ch_en <= 6'(k * 9);
         dis_set <= 6'(k * 5) ^ 6'h33;
         th_r <= 8'(k * 37);
         th_f <= 8'(k * 11);
         wait_cyc(2);
         check("discharge", 8'(~ch_en & dis_set), 8'(dis_o));
         check("rise thr", th_r, rise_o);
         check("fall thr", th_f, fall_o);
      end
      hold = ~ch_en & dis_set;
      @(posedge clk_sys);
      ce <= 1'b0;
      ch_en <= ~ch_en;
      wait_cyc(3);
      check("frozen", 8'(hold), 8'(dis_o));
      @(posedge clk_sys);
      ce <= 1'b1;
   endtask

   task automatic t_por();
      @(posedge clk_sys);
      above <= 1'b1;
      wait_cyc(N_DLY + 2);
      check("por early", 8'h01, 8'(por_oe));
      wait_cyc(6);
      check("por release", 8'h00, 8'(por_oe));
      @(posedge clk_sys);
      below <= 1'b1;
      above <= 1'b0;
      wait_cyc(5);
      check("por assert", 8'h01, 8'(por_oe));
      @(posedge clk_sys);
      below <= 1'b0;
      above <= 1'b1;
      wait_cyc(8);
      @(posedge clk_sys);
      below <= 1'b1;
      wait_cyc(N_DLY + 8);
      check("por abort", 8'h01, 8'(por_oe));
   endtask

   initial begin
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'b1;
      wait_cyc(5);
      judge(1'b0, 0, rst_cnt);
      check("por rst", 8'h01, 8'(por_oe));
      check("oe rst", 8'h00, 8'(s_oe));
      pin_step(1'b0, 1'b1, 0);
      pin_step(1'b1, 1'b0, 1);
      @(posedge clk_sys);
      edge_r <= 1'b1;
      pin_step(1'b0, 1'b0, 0);
      pin_step(1'b1, 1'b1, 0);
      pin_step(1'b0, 1'b0, 1);
      @(posedge clk_sys);
      edge_r <= 1'b0;
      pin_step(1'b1, 1'b0, 0);
      ser_step(8'h00, 80, 1'b1, 0);
      ser_step(8'hFE, 80, 1'b1, 0);
      ser_step(8'hA5, 80, 1'b0, 1);
      pin_step(1'b0, 1'b1, 0);
      ser_step(8'h01, 80, 1'b0, 1);
      pin_step(1'b1, 1'b0, 0);
      t_discharge();
      t_por();
      test_done();
   end
endmodule // sbypor_top_tb
